// File: hdl/bcu_pkg.sv
// Shared constants and types for the local bus cycle unit.
package bcu_pkg;
	// ****************************************
	// Bus status codes, driven on the three status outputs.
	// ****************************************
	localparam logic [2:0] BCU_ST_INT_ACK_STROBE = 3'h0;
	localparam logic [2:0] BCU_ST_IO_RD = 3'h1;
	localparam logic [2:0] BCU_ST_IO_WR = 3'h2;
	localparam logic [2:0] BCU_ST_HALT = 3'h3;
	localparam logic [2:0] BCU_ST_CODE = 3'h4;
	localparam logic [2:0] BCU_ST_MEM_RD = 3'h5;
	localparam logic [2:0] BCU_ST_MEM_WR = 3'h6;
	localparam logic [2:0] BCU_ST_PASSIVE = 3'h7;

	// ****************************************
	// Segment codes, bit a in position 0 and bit b in position 1.
	// ****************************************
	localparam logic [1:0] BCU_SEG_ALT = 2'h0;
	localparam logic [1:0] BCU_SEG_STACK = 2'h1;
	localparam logic [1:0] BCU_SEG_CODE = 2'h2;
	localparam logic [1:0] BCU_SEG_DATA = 2'h3;

	// ****************************************
	// Field positions and reset values.
	// ****************************************
	localparam int BCU_UPPER_LSB = 16;
	localparam int BCU_STAT_SEG_A = 0;
	localparam int BCU_STAT_SEG_B = 1;
	localparam int BCU_STAT_IF = 2;
	localparam logic BCU_HIGH_STATUS_RST = 1'h0;
	localparam logic [15:0] BCU_DATA_RST = 16'h0000;

	// Bus cycle states.
	typedef enum logic [2:0] {
		BCU_IDLE,
		BCU_T1,
		BCU_T2,
		BCU_T3,
		BCU_TW,
		BCU_T4,
		BCU_HOLD
	} bcu_state_t;
endpackage : bcu_pkg

// File: hdl/bcu_bus_cycle.sv
// Local bus cycle sequencer of a 16-bit processor: T-states, pins and hold.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Ready is sampled in T3 and each wait state, and a wait state follows while it is low.
// - An interrupt acknowledge runs two acknowledge cycles back to back with nothing between.
// - The multiplexed lines float during both acknowledge cycles so the vector can be driven.
// - The bus status returns to passive in the state just before T4.
// - The multiplexed lines carry the address in T1 and data in T2, T3, wait states and T4.
// - In T1 line 0 is low when the lower byte is used and high when it is not.
// - The multiplexed lines float throughout interrupt acknowledge and hold acknowledge.
// - The upper four lines carry address bits 19 to 16 in T1 of memory cycles.
// - The upper four lines are low in T1 of I/O cycles.
// - The upper four lines carry status in T2, T3, wait states and T4.
// - Segment bits a,b encode 0,0 alternate, 1,0 stack, 0,1 code or none, 1,1 data.
// - The upper four lines float for the whole of hold acknowledge.
// - The high byte line shows the upper byte enable in T1 and a status bit afterwards.
// - The address latch pulse is positive, latches on its trailing edge and never floats.
module bcu_bus_cycle
	import bcu_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	// Request side.
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [2:0] req_kind_in,
	input wire logic [19:0] req_addr_in,
	input wire logic req_low_byte_in,
	input wire logic req_high_byte_in,
	input wire logic [15:0] req_wdata_in,
	input wire logic [1:0] req_segment_in,
	input wire logic int_enable_flag_in,
	output logic done_out,
	output logic [15:0] rdata_out,
	// Bus pins.
	input wire logic [15:0] addr_data_lines_in,
	output logic [15:0] addr_data_lines_out,
	output logic addr_data_lines_oe_out,
	output logic [3:0] upper_addr_status_lines_out,
	output logic upper_addr_status_lines_oe_out,
	output logic high_byte_enable_status_out,
	output logic high_byte_enable_status_oe_out,
	output logic addr_latch_out,
	output logic int_ack_strobe_n_out,
	output logic [2:0] bus_status_out,
	output logic bus_status_oe_out,
	input wire logic ready_in,
	input wire logic hold_in,
	output logic hold_ack_out
);
	// ****************************************
	// State and captured request.
	// ****************************************
	bcu_state_t state_reg;
	bcu_state_t state_next;
	logic [2:0] kind_reg;
	logic [19:0] addr_reg;
	logic low_byte_reg;
	logic high_byte_reg;
	logic [15:0] wdata_reg;
	logic [1:0] segment_reg;
	logic if_flag_reg;
	logic second_ack_reg;
	logic take_req;
	logic [15:0] rdata_reg;
	logic done_reg;

	// Kind decoders shared by several processes.
	function automatic logic bcu_is_int_ack_strobe(input logic [2:0] kind);
		return kind == BCU_ST_INT_ACK_STROBE;
	endfunction : bcu_is_int_ack_strobe

	function automatic logic bcu_is_write(input logic [2:0] kind);
		return (kind == BCU_ST_IO_WR) || (kind == BCU_ST_MEM_WR);
	endfunction : bcu_is_write

	function automatic logic bcu_is_io(input logic [2:0] kind);
		return ~kind[2];
	endfunction : bcu_is_io

	// A new cycle may start from idle or straight after T4, but never while hold is asked
	// for, and never between the two acknowledge cycles, which must stay back to back.
	assign req_ready_out = ((state_reg == BCU_IDLE) ||
		((state_reg == BCU_T4) && !second_ack_reg)) && !hold_in;
	assign take_req = req_valid_in && req_ready_out;

	// Fields of the cycle about to enter T1: the request taken at this edge, or, when the
	// second acknowledge cycle follows its twin, the fields captured with the first one.
	// Reading the raw request there would put a stale address on the pins.
	logic [19:0] t1_addr;
	logic [2:0] t1_kind;
	logic t1_low;
	logic t1_high;
	assign t1_addr = take_req ? req_addr_in : addr_reg;
	assign t1_kind = take_req ? req_kind_in : kind_reg;
	assign t1_low = take_req ? req_low_byte_in : low_byte_reg;
	assign t1_high = take_req ? req_high_byte_in : high_byte_reg;

	// ****************************************
	// Next state.
	// ****************************************
	// Hold is honoured only from idle or at the end of a cycle, never inside one, and never
	// between the two acknowledge cycles, where T4 runs straight into the next T1.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			BCU_IDLE: begin
				if (hold_in) begin
					state_next = BCU_HOLD;
				end else if (req_valid_in) begin
					state_next = BCU_T1;
				end
			end
			BCU_HOLD: begin
				if (!hold_in) begin
					state_next = BCU_IDLE;
				end
			end
			BCU_T1: state_next = BCU_T2;
			BCU_T2: state_next = BCU_T3;
			// A low ready from the slave holds the cycle in wait states.
			BCU_T3, BCU_TW: begin
				state_next = ready_in ? BCU_T4 : BCU_TW;
			end
			BCU_T4: begin
				if (second_ack_reg) begin
					state_next = BCU_T1;
				end else if (hold_in) begin
					state_next = BCU_HOLD;
				end else if (req_valid_in) begin
					state_next = BCU_T1;
				end else begin
					state_next = BCU_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= BCU_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Request capture and acknowledge pairing.
	// ****************************************
	// Fields are kept for the whole cycle so the second acknowledge cycle can reuse them.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			kind_reg <= BCU_ST_PASSIVE;
			addr_reg <= 20'h00000;
			low_byte_reg <= 1'h0;
			high_byte_reg <= 1'h0;
			wdata_reg <= BCU_DATA_RST;
			segment_reg <= BCU_SEG_CODE;
			if_flag_reg <= 1'h0;
		end else if (take_req) begin
			kind_reg <= req_kind_in;
			addr_reg <= req_addr_in;
			low_byte_reg <= req_low_byte_in;
			high_byte_reg <= req_high_byte_in;
			wdata_reg <= req_wdata_in;
			segment_reg <= req_segment_in;
			if_flag_reg <= int_enable_flag_in;
		end
	end

	// The flag marks that the cycle under way is the first of an acknowledge pair, so
	// its T4 leads straight into the second T1, with no idle state left between the
	// two cycles.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			second_ack_reg <= 1'h0;
		end else if (take_req) begin
			second_ack_reg <= bcu_is_int_ack_strobe(req_kind_in);
		end else if ((state_reg == BCU_T4) && second_ack_reg) begin
			second_ack_reg <= 1'h0;
		end
	end

	// ****************************************
	// Read data and completion.
	// ****************************************
	// Read data is taken on the edge that leaves the last T3 or wait state.
	// The done pulse follows T4 by one clock; after an acknowledge pair only the second counts.
	// The read data stands until the next cycle that is not a write, so a write leaves it untouched.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_reg <= BCU_DATA_RST;
			done_reg <= 1'h0;
		end else begin
			done_reg <= (state_reg == BCU_T4) && !second_ack_reg;
			if (((state_reg == BCU_T3) || (state_reg == BCU_TW)) && ready_in &&
				!bcu_is_write(kind_reg)) begin
				rdata_reg <= addr_data_lines_in;
			end
		end
	end
	assign rdata_out = rdata_reg;
	assign done_out = done_reg;

	// ****************************************
	// Multiplexed address and data lines.
	// ****************************************
	// Driven from the next state so the pins change right at each T-state edge.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_data_lines_out <= BCU_DATA_RST;
			addr_data_lines_oe_out <= 1'h0;
		end else if (state_next == BCU_T1) begin
			// The address phase of an acknowledge cycle stays floating as well.
			addr_data_lines_out <= {t1_addr[15:1], ~t1_low};
			addr_data_lines_oe_out <= !bcu_is_int_ack_strobe(t1_kind);
		end else if ((state_next == BCU_T2) || (state_next == BCU_T3) ||
			(state_next == BCU_TW) || (state_next == BCU_T4)) begin
			addr_data_lines_out <= wdata_reg;
			addr_data_lines_oe_out <= bcu_is_write(kind_reg);
		end else begin
			// Outside a cycle the lines float so a hold requester may take them.
			addr_data_lines_out <= BCU_DATA_RST;
			addr_data_lines_oe_out <= 1'h0;
		end
	end

	// ****************************************
	// Upper address/status and high byte lines.
	// ****************************************
	// Address and byte enable in T1, status afterwards, floating from reset or hold until the next T1.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			upper_addr_status_lines_out <= 4'h0;
			upper_addr_status_lines_oe_out <= 1'h0;
			high_byte_enable_status_out <= 1'h1;
			high_byte_enable_status_oe_out <= 1'h0;
		end else if (state_next == BCU_T1) begin
			// I/O ports live below 64K, so the top bits are forced low.
			if (bcu_is_io(t1_kind)) begin
				upper_addr_status_lines_out <= 4'h0;
			end else begin
				upper_addr_status_lines_out <= t1_addr[19:16];
			end
			upper_addr_status_lines_oe_out <= 1'h1;
			high_byte_enable_status_out <= ~t1_high;
			high_byte_enable_status_oe_out <= 1'h1;
		end else if (state_next == BCU_HOLD) begin
			// The latch pulse, acknowledge strobe and hold acknowledge outputs keep driving in hold.
			upper_addr_status_lines_oe_out <= 1'h0;
			high_byte_enable_status_oe_out <= 1'h0;
		end else if (state_next != BCU_IDLE) begin
			upper_addr_status_lines_out[BCU_STAT_SEG_A] <= segment_reg[0];
			upper_addr_status_lines_out[BCU_STAT_SEG_B] <= segment_reg[1];
			upper_addr_status_lines_out[BCU_STAT_IF] <= if_flag_reg;
			upper_addr_status_lines_out[3] <= 1'h0;
			high_byte_enable_status_out <= BCU_HIGH_STATUS_RST;
		end
	end

	// ****************************************
	// Latch pulse, acknowledge strobe and hold acknowledge.
	// ****************************************
	// The latch pulse is high for all of T1 and falls at T2, on the same edge that takes
	// the address off the lines; it is driven in every state, hold included.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_latch_out <= 1'h0;
			int_ack_strobe_n_out <= 1'h1;
			hold_ack_out <= 1'h0;
		end else begin
			addr_latch_out <= (state_next == BCU_T1);
			int_ack_strobe_n_out <= !(bcu_is_int_ack_strobe(kind_reg) &&
				((state_next == BCU_T2) || (state_next == BCU_T3) ||
				(state_next == BCU_TW)));
			hold_ack_out <= (state_next == BCU_HOLD);
		end
	end

	// ****************************************
	// Bus status.
	// ****************************************
	// Status is active from T1 and drops to passive as soon as ready is seen in T3 or a
	// wait state, which is the state just before T4. This path is combinational from
	// ready so the controller can end its command without waiting a whole state.
	always_comb begin
		bus_status_out = BCU_ST_PASSIVE;
		unique case (state_reg)
			BCU_T1, BCU_T2: bus_status_out = kind_reg;
			BCU_T3, BCU_TW: bus_status_out = ready_in ? BCU_ST_PASSIVE : kind_reg;
			default: bus_status_out = BCU_ST_PASSIVE;
		endcase
	end
	assign bus_status_oe_out = (state_reg != BCU_HOLD);
endmodule : bcu_bus_cycle

`default_nettype wire

// File: verification/bcu_checker.sv
// Pin-level checks for the local bus cycle unit.
`timescale 1ns/1ns
`default_nettype none
module bcu_checker
	import bcu_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [19:0] req_addr_in,
	input wire logic req_low_byte_in,
	input wire logic [1:0] req_segment_in,
	input wire logic done_out,
	input wire logic [15:0] addr_data_lines_out,
	input wire logic addr_data_lines_oe_out,
	input wire logic [3:0] upper_addr_status_lines_out,
	input wire logic upper_addr_status_lines_oe_out,
	input wire logic high_byte_enable_status_oe_out,
	input wire logic addr_latch_out,
	input wire logic [2:0] bus_status_out,
	input wire logic bus_status_oe_out,
	input wire logic ready_in,
	input wire logic hold_ack_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ****************************************
	// Helpers
	// ****************************************
	logic t1_req;
	logic t1_ack;
	logic odd_ack_reg;
	// Address phase of an ordinary cycle and of an acknowledge cycle.
	assign t1_req = addr_latch_out && bus_status_out != BCU_ST_INT_ACK_STROBE;
	assign t1_ack = addr_latch_out && bus_status_out == BCU_ST_INT_ACK_STROBE;
	// Parity of acknowledge address phases; odd means the pair is still open.
	always_ff @(posedge clk_in) begin
		odd_ack_reg <= !rst_in && ((odd_ack_reg && !done_out) ^ t1_ack);
	end
	sequence s_t2;
		$fell(addr_latch_out) && bus_status_out != BCU_ST_INT_ACK_STROBE;
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	a_latch_pulse: assert property (addr_latch_out |=> !addr_latch_out)
		else $error("latch held past T1");
	a_addr_phase: assert property (t1_req |-> addr_data_lines_oe_out &&
		addr_data_lines_out == {$past(req_addr_in[15:1]), !$past(req_low_byte_in)})
		else $error("bad address phase");
	a_upper_addr: assert property (t1_req |-> upper_addr_status_lines_out ==
		(bus_status_out[2] ? $past(req_addr_in[19:16]) : 4'h0))
		else $error("bad upper address");
	a_upper_stat: assert property (s_t2 |-> !upper_addr_status_lines_out[3] &&
		upper_addr_status_lines_out[1:0] == $past(req_segment_in, 2))
		else $error("bad segment status");
	a_passive_t3: assert property (s_t2 ##1 ready_in |-> bus_status_out == BCU_ST_PASSIVE)
		else $error("status not passive");
	a_done_time: assert property (s_t2 ##1 ready_in |-> ##2 done_out)
		else $error("cycle length wrong");
	a_wait_ins: assert property (s_t2 ##1 !ready_in |-> ##2 !done_out)
		else $error("wait state skipped");
	a_ack_float: assert property (bus_status_oe_out && bus_status_out == BCU_ST_INT_ACK_STROBE
		|-> !addr_data_lines_oe_out) else $error("lines driven in ack");
	a_hold_float: assert property (hold_ack_out |-> !(addr_data_lines_oe_out ||
		upper_addr_status_lines_oe_out || high_byte_enable_status_oe_out || bus_status_oe_out))
		else $error("pins driven in hold");
	a_ack_pair: assert property (t1_req || done_out |-> !odd_ack_reg)
		else $error("ack pair split");
endmodule : bcu_checker
`default_nettype wire

// File: verification/bcu_slave_model.sv
// Behavioural memory, port and vector responder on the local bus.
`timescale 1ns/1ns
`default_nettype none
module bcu_slave_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic latch_in,
	input wire logic done_in,
	input wire logic ad_oe_in,
	input wire logic [3:0] waits_in,
	output logic ready_out,
	output logic drive_out
);
	logic busy_reg;
	logic [3:0] cnt_reg;
	// The stall restarts at each address phase, so both ack cycles stall alike.
	always_ff @(posedge clk_in) begin
		if (rst_in || latch_in) begin
			cnt_reg <= rst_in ? 4'h0 : waits_in;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
	// A transfer stays open until completion, spanning the whole ack pair.
	always_ff @(posedge clk_in) begin
		busy_reg <= !rst_in && (latch_in || (busy_reg && !done_in));
	end
	assign ready_out = (cnt_reg == 4'h0);
	// Data or vector only while the unit has let go of the lines.
	assign drive_out = busy_reg && !latch_in && !ad_oe_in;
endmodule : bcu_slave_model
`default_nettype wire

// File: verification/bcu_bus_cycle_tb.sv
// Self-checking bench for the local bus cycle unit.
`timescale 1ns/1ns
`default_nettype none
`define check_eq(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module bcu_bus_cycle_tb
	import bcu_pkg::*;
;
	logic clk_in = 1'h0, rst_in = 1'h1, req_valid = 1'h0, lo = 1'h0, hi = 1'h0;
	logic ief = 1'h0, hold = 1'h0;
	logic req_ready, done, latch, strobe_n, ad_oe, up_oe, hb, hb_oe, st_oe, ready, hack, drv;
	logic [2:0] kind = 3'h0, st;
	logic [19:0] addr = 20'h0;
	logic [15:0] wdata = 16'h0, rdata, ad_out, ad_in, ad_last = 16'h0, vec = 16'h0;
	logic [1:0] seg = 2'h0;
	logic [3:0] up, waits = 4'h0;
	int err_count = 0, tests_run = 0;
	always #4 clk_in = ~clk_in;
	// Undriven lines toggle so a stale value is never mistaken for data.
	assign ad_in = ad_oe ? ad_out : (drv ? vec : ~ad_last);
	always @(posedge clk_in) ad_last <= ad_in;
	bcu_bus_cycle bcu_bus_cycle_inst (.clk_in(clk_in), .rst_in(rst_in),
		.req_valid_in(req_valid), .req_ready_out(req_ready), .req_kind_in(kind),
		.req_addr_in(addr), .req_low_byte_in(lo), .req_high_byte_in(hi),
		.req_wdata_in(wdata), .req_segment_in(seg), .int_enable_flag_in(ief),
		.done_out(done), .rdata_out(rdata), .addr_data_lines_in(ad_in),
		.addr_data_lines_out(ad_out), .addr_data_lines_oe_out(ad_oe),
		.upper_addr_status_lines_out(up), .upper_addr_status_lines_oe_out(up_oe),
		.high_byte_enable_status_out(hb), .high_byte_enable_status_oe_out(hb_oe),
		.addr_latch_out(latch), .int_ack_strobe_n_out(strobe_n), .bus_status_out(st),
		.bus_status_oe_out(st_oe), .ready_in(ready), .hold_in(hold), .hold_ack_out(hack));
	bcu_slave_model bcu_slave_model_inst (.clk_in(clk_in), .rst_in(rst_in), .latch_in(latch),
		.done_in(done), .ad_oe_in(ad_oe), .waits_in(waits), .ready_out(ready),
		.drive_out(drv));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic test_done;
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// One request, held until taken, then judged pin by pin until completion.
	task automatic run_cycle(input logic [2:0] k, input logic [19:0] a,
		input logic [1:0] s, input logic [3:0] w);
		int i;
		int exp;
		logic drove;
		drove = 1'h0;
		exp = (k == 3'h0 ? 2 : 1) * (4 + (w > 4'h0 ? w - 1 : 0)) + 1;
		@(posedge clk_in);
		req_valid <= 1'h1;
		kind <= k;
		addr <= a;
		seg <= s;
		waits <= w;
		lo <= !a[0];
		hi <= a[0];
		ief <= a[1];
		wdata <= ~a[15:0];
		vec <= a[15:0] ^ 16'h5a5a;
		for (i = 0; i < 20; i++) begin
			@(negedge clk_in);
			if (req_ready) break;
		end
		if (i == 20) begin err_count++; test_done; end
		@(posedge clk_in);
		req_valid <= 1'h0;
		for (i = 1; i < 40; i++) begin
			@(negedge clk_in);
			if (ad_oe && k == 3'h0) drove = 1'h1;
			if (i == 1 && k != 3'h0) `check_eq("upper t1", k[2] ? a[19:16] : 4'h0, up)
			if (i == 1) `check_eq("high enable", !a[0], hb)
			if (i == 1) `check_eq("latch t1", 1'h1, latch)
			if (i == 2 && k != 3'h0) `check_eq("segment", {1'h0, a[1], s}, up)
			if (i == 2) `check_eq("high status", 1'h0, hb)
			if (i == 2) `check_eq("ack strobe", k != 3'h0, strobe_n)
			if (i == 2 && k[1:0] == 2'h2) `check_eq("wdata", ~a[15:0], ad_in)
			if (done) break;
		end
		if (i == 40) begin err_count++; test_done; end
		`check_eq("length", exp, i)
		if (!k[1]) `check_eq("rdata", a[15:0] ^ 16'h5a5a, rdata)
		if (k == 3'h0) `check_eq("ack float", 1'h0, drove)
	endtask : run_cycle
	task automatic t_reset;
		@(negedge clk_in);
		`check_eq("latch", 1'h0, latch)
		`check_eq("status", BCU_ST_PASSIVE, st)
	endtask : t_reset
	// Every kind except acknowledge and halt, every segment code, and stalls of zero to two wait states.
	task automatic t_kinds;
		logic [2:0] ks [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
		for (int n = 0; n < 8; n++) begin
			run_cycle(ks[n % 5], {n[3:0] ^ 4'h9, 12'he37, n[3:0]}, n[1:0], {2'h0, n[2:1]});
		end
	endtask : t_kinds
	task automatic t_ack;
		run_cycle(3'h0, 20'h0, 2'h2, 4'h0);
		run_cycle(3'h0, 20'h0, 2'h2, 4'h3);
	endtask : t_ack
	task automatic t_hold;
		@(posedge clk_in);
		hold <= 1'h1;
		repeat (2) @(negedge clk_in);
		`check_eq("hold ack", 1'h1, hack)
		`check_eq("float", 4'h0, {ad_oe, up_oe, hb_oe, st_oe})
		`check_eq("latch", 1'h0, latch)
		`check_eq("refused", 1'h0, req_ready)
		@(posedge clk_in);
		hold <= 1'h0;
		repeat (2) @(negedge clk_in);
		`check_eq("hold end", 1'h0, hack)
	endtask : t_hold
	// Main sequence.
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		t_reset();
		t_kinds();
		t_ack();
		t_hold();
		run_cycle(3'h5, 20'h4c0d3, 2'h3, 4'h2);
		test_done();
	end
endmodule : bcu_bus_cycle_tb
bind bcu_bus_cycle bcu_checker bcu_checker_inst (.clk_in(clk_in), .rst_in(rst_in),
	.req_addr_in(req_addr_in), .req_low_byte_in(req_low_byte_in),
	.req_segment_in(req_segment_in), .done_out(done_out),
	.addr_data_lines_out(addr_data_lines_out), .addr_data_lines_oe_out(addr_data_lines_oe_out),
	.upper_addr_status_lines_out(upper_addr_status_lines_out),
	.upper_addr_status_lines_oe_out(upper_addr_status_lines_oe_out),
	.high_byte_enable_status_oe_out(high_byte_enable_status_oe_out),
	.addr_latch_out(addr_latch_out), .bus_status_out(bus_status_out),
	.bus_status_oe_out(bus_status_oe_out), .ready_in(ready_in), .hold_ack_out(hold_ack_out));
`default_nettype wire
